// ---- hw/plcr_lockfield.v ----
/*
 * lockable read-write field: software writes land only while the
 * unlock control is set; hardware load has priority over writes.
 * assumes synchronous active-high reset and one clock.
 */
`timescale 1ns/1ps

module plcr_lockfield #(
	parameter W = 4
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	// reset and hardware load values
	input  wire [W-1:0] rst_val_i,
	input  wire         hw_load_i,
	input  wire [W-1:0] hw_val_i,
	// software write
	input  wire         wr_i,
	input  wire         unlock_i,
	input  wire [W-1:0] wdata_i,
	// field value
	output wire [W-1:0] q_o
);

	reg [W-1:0] field_q;
	reg [W-1:0] field_d;

	// next value: hardware load, then unlocked write, else hold
	always @* begin
		field_d = field_q;
		if (hw_load_i) begin
			field_d = hw_val_i;
		end else if (wr_i && unlock_i) begin
			field_d = wdata_i;
		end
	end

	// field storage
	always @(posedge clk_i) begin
		if (rst_i) begin
			field_q <= rst_val_i;
		end else begin
			field_q <= field_d;
		end
	end

	assign q_o = field_q;

endmodule // plcr_lockfield

// ---- hw/plcr_rdport.v ----
/*
 * read data register of the configuration port: presents the
 * selected word in the cycle after the read strobe, zero otherwise.
 * assumes synchronous active-high reset and one clock.
 */
`timescale 1ns/1ps
`include "plcr_regs.vh"

module plcr_rdport (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// read request
	input  wire        rd_i,
	input  wire [31:0] word_i,
	// read data
	output wire [31:0] rdata_o
);

	reg [31:0] rdata_q;
	reg [31:0] rdata_d;

	// data only in the cycle after a strobe
	always @* begin
		rdata_d = `PLCR_ZERO32;
		if (rd_i) begin
			rdata_d = word_i;
		end
	end

	// read data flop
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= `PLCR_ZERO32;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

endmodule // plcr_rdport

// ---- hw/plcr_regs.vh ----
/*
 * register map, field positions, reset values and codes of the
 * per-port link capability word and its companion control word.
 * assumes byte addressing on a 12-bit configuration address.
 */
`ifndef PLCR_REGS_VH
`define PLCR_REGS_VH

// ------------------------------------------------------------------
// offsets
// ------------------------------------------------------------------
`define PLCR_AW                12
`define PLCR_OFF_LINK_CAP      12'h04c
`define PLCR_OFF_PORT_CTRL     12'h0f0

// ------------------------------------------------------------------
// link capability word fields
// ------------------------------------------------------------------
`define PLCR_SPD_LSB           0
`define PLCR_SPD_MSB           3
`define PLCR_WID_LSB           4
`define PLCR_WID_MSB           9
`define PLCR_PSS_LSB           10
`define PLCR_PSS_MSB           11
`define PLCR_L0S_LSB           12
`define PLCR_L0S_MSB           14
`define PLCR_L1_LSB            15
`define PLCR_L1_MSB            17
`define PLCR_CPM_BIT           18
`define PLCR_SDE_BIT           19
`define PLCR_DLA_BIT           20
`define PLCR_BWN_BIT           21
`define PLCR_RSV_LSB           22
`define PLCR_RSV_MSB           23
`define PLCR_PORT_LSB          24
`define PLCR_PORT_MSB          31

// ------------------------------------------------------------------
// port control word fields
// ------------------------------------------------------------------
`define PLCR_CTL_UNLOCK_BIT    0
`define PLCR_CTL_SHCLK_BIT     6

// ------------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------------
`define PLCR_SPD_RST           4'h1
`define PLCR_SPD_GEN1          4'h1
`define PLCR_SPD_GEN2          4'h2
`define PLCR_PSS_FIXED         2'h3
`define PLCR_L0S_SEPARATE      3'h5
`define PLCR_L0S_COMMON        3'h3
`define PLCR_L1_RST            3'h2
`define PLCR_CPM_RST           1'h0
`define PLCR_WID_X1            6'h01
`define PLCR_WID_X2            6'h02
`define PLCR_WID_X4            6'h04
`define PLCR_RSV_VAL           2'h0
`define PLCR_ZERO32            32'h0000_0000

`endif

// ---- hw/plcr_top.v ----
/*
 * per-port link capability word of a switch port, with a small
 * port control word holding the unlock and shared-refclk bits.
 * assumes a plain register port (address, data, strobes), read data
 * one cycle after the read strobe, and port straps held steady.
 */
`timescale 1ns/1ps
`include "plcr_regs.vh"

module plcr_top (
	// clock and reset
	input  wire                  CLK_I,
	input  wire                  SYS_RST_I,
	// register port
	input  wire [`PLCR_AW-1:0]   ADDR_I,
	input  wire [31:0]           WDATA_I,
	input  wire                  WR_I,
	input  wire                  RD_I,
	output wire [31:0]           RDATA_O,
	// port straps
	input  wire                  UPSTREAM_I,
	input  wire                  LEGACY_MODE_I,
	input  wire [7:0]            PORT_NUM_I,
	input  wire [5:0]            CFG_WIDTH_I,
	// capability outputs to the link logic
	output wire [3:0]            MAX_SPEED_O,
	output wire [5:0]            TRAIN_WIDTH_O,
	output wire [2:0]            QUICK_EXIT_LAT_O,
	output wire                  SHARED_REFCLK_O,
	output wire                  UNLOCKED_O
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// width codes the port can train at
	function width_valid;
		input [5:0] w;
		begin
			width_valid = (w == `PLCR_WID_X1) || (w == `PLCR_WID_X2) ||
				(w == `PLCR_WID_X4);
		end
	endfunction

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------

	wire cap_hit;
	wire ctl_hit;
	wire cap_wr;
	wire ctl_wr;

	// word selects and write qualifiers
	assign cap_hit = (ADDR_I == `PLCR_OFF_LINK_CAP);
	assign ctl_hit = (ADDR_I == `PLCR_OFF_PORT_CTRL);
	assign cap_wr  = WR_I && cap_hit;
	assign ctl_wr  = WR_I && ctl_hit;

	// ------------------------------------------------------------------
	// port control word
	// ------------------------------------------------------------------

	reg unlock_q;
	reg unlock_d;
	reg shclk_q;
	reg shclk_d;

	// unlock and shared refclk bits, plain read-write
	always @* begin
		unlock_d = unlock_q;
		shclk_d  = shclk_q;
		if (ctl_wr) begin
			unlock_d = WDATA_I[`PLCR_CTL_UNLOCK_BIT];
			shclk_d  = WDATA_I[`PLCR_CTL_SHCLK_BIT];
		end
	end

	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			unlock_q <= 1'b0;
			shclk_q  <= 1'b0;
		end else begin
			unlock_q <= unlock_d;
			shclk_q  <= shclk_d;
		end
	end

	// ------------------------------------------------------------------
	// initialisation of hardware-set fields
	// ------------------------------------------------------------------

	reg init_done_q;

	// one load of the configured width after reset release
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			init_done_q <= 1'b0;
		end else begin
			init_done_q <= 1'b1;
		end
	end

	wire init_load;
	assign init_load = !init_done_q;

	// port role strap caught at the first cycle after release
	reg upstream_q;

	always @(posedge CLK_I) begin
		if (init_load) begin
			upstream_q <= UPSTREAM_I;
		end
	end

	// ------------------------------------------------------------------
	// lockable fields
	// ------------------------------------------------------------------

	wire [3:0] max_speed_field;
	wire [5:0] max_width_field;
	wire [2:0] deep_idle_exit_latency;
	wire       refclk_removal_capable;
	wire       surprise_down_capable;
	wire       link_active_raw;
	wire       bandwidth_notify_raw;

	// max speed, reset to gen1
	plcr_lockfield #(.W(4)) u_speed (
		.clk_i     (CLK_I),
		.rst_i     (SYS_RST_I),
		.rst_val_i (`PLCR_SPD_RST),
		.hw_load_i (1'b0),
		.hw_val_i  (`PLCR_SPD_RST),
		.wr_i      (cap_wr),
		.unlock_i  (unlock_q),
		.wdata_i   (WDATA_I[`PLCR_SPD_MSB:`PLCR_SPD_LSB]),
		.q_o       (max_speed_field)
	);

	// max width, loaded with the configured width after init
	plcr_lockfield #(.W(6)) u_width (
		.clk_i     (CLK_I),
		.rst_i     (SYS_RST_I),
		.rst_val_i (`PLCR_WID_X1),
		.hw_load_i (init_load),
		.hw_val_i  (CFG_WIDTH_I),
		.wr_i      (cap_wr),
		.unlock_i  (unlock_q),
		.wdata_i   (WDATA_I[`PLCR_WID_MSB:`PLCR_WID_LSB]),
		.q_o       (max_width_field)
	);

	// deep idle exit latency, default 2-4 us
	plcr_lockfield #(.W(3)) u_l1 (
		.clk_i     (CLK_I),
		.rst_i     (SYS_RST_I),
		.rst_val_i (`PLCR_L1_RST),
		.hw_load_i (1'b0),
		.hw_val_i  (`PLCR_L1_RST),
		.wr_i      (cap_wr),
		.unlock_i  (unlock_q),
		.wdata_i   (WDATA_I[`PLCR_L1_MSB:`PLCR_L1_LSB]),
		.q_o       (deep_idle_exit_latency)
	);

	// role-dependent capability bits, set from the straps at init; refclk removal loads 0
	wire [3:0] misc_init;
	wire [3:0] misc_q;

	assign misc_init = {
		!UPSTREAM_I && !LEGACY_MODE_I,
		!UPSTREAM_I,
		!UPSTREAM_I,
		`PLCR_CPM_RST
	};

	plcr_lockfield #(.W(4)) u_misc (
		.clk_i     (CLK_I),
		.rst_i     (SYS_RST_I),
		.rst_val_i (4'h0),
		.hw_load_i (init_load),
		.hw_val_i  (misc_init),
		.wr_i      (cap_wr),
		.unlock_i  (unlock_q),
		.wdata_i   (WDATA_I[`PLCR_BWN_BIT:`PLCR_CPM_BIT]),
		.q_o       (misc_q)
	);

	assign refclk_removal_capable = misc_q[0];
	assign surprise_down_capable  = misc_q[1];
	assign link_active_raw        = misc_q[2];
	assign bandwidth_notify_raw   = misc_q[3];

	// link active reporting never shows on the upstream port
	wire link_active_report_capable;
	wire bandwidth_notify_capable;

	assign link_active_report_capable = link_active_raw && !upstream_q;
	assign bandwidth_notify_capable   = bandwidth_notify_raw;

	// ------------------------------------------------------------------
	// quick idle exit latency
	// ------------------------------------------------------------------

	reg       l0s_ovr_q;
	reg       l0s_ovr_d;
	reg [2:0] l0s_val_q;
	reg [2:0] l0s_val_d;

	// unlocked write pins a value; otherwise it tracks the clock mode
	always @* begin
		l0s_ovr_d = l0s_ovr_q;
		l0s_val_d = l0s_val_q;
		if (cap_wr && unlock_q) begin
			l0s_ovr_d = 1'b1;
			l0s_val_d = WDATA_I[`PLCR_L0S_MSB:`PLCR_L0S_LSB];
		end
	end

	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			l0s_ovr_q <= 1'b0;
			l0s_val_q <= `PLCR_L0S_SEPARATE;
		end else begin
			l0s_ovr_q <= l0s_ovr_d;
			l0s_val_q <= l0s_val_d;
		end
	end

	wire [2:0] quick_idle_exit_latency;

	// common refclk 256-512 ns, separate refclk 1-2 us
	assign quick_idle_exit_latency = l0s_ovr_q ? l0s_val_q :
		(shclk_q ? `PLCR_L0S_COMMON
		         : `PLCR_L0S_SEPARATE);

	// ------------------------------------------------------------------
	// capability word assembly
	// ------------------------------------------------------------------

	wire [31:0] cap_word;
	wire [31:0] ctl_word;

	assign cap_word = {
		PORT_NUM_I,
		`PLCR_RSV_VAL,
		bandwidth_notify_capable,
		link_active_report_capable,
		surprise_down_capable,
		refclk_removal_capable,
		deep_idle_exit_latency,
		quick_idle_exit_latency,
		`PLCR_PSS_FIXED,
		max_width_field,
		max_speed_field
	};

	assign ctl_word = {
		25'h0000000,
		shclk_q,
		5'h00,
		unlock_q
	};

	// ------------------------------------------------------------------
	// read port
	// ------------------------------------------------------------------

	reg [31:0] rd_word;

	// unmapped addresses read as zero
	always @* begin
		rd_word = `PLCR_ZERO32;
		if (cap_hit) begin
			rd_word = cap_word;
		end else if (ctl_hit) begin
			rd_word = ctl_word;
		end
	end

	plcr_rdport u_rdport (
		.clk_i   (CLK_I),
		.rst_i   (SYS_RST_I),
		.rd_i    (RD_I),
		.word_i  (rd_word),
		.rdata_o (RDATA_O)
	);

	// ------------------------------------------------------------------
	// outputs to the link logic
	// ------------------------------------------------------------------

	reg [3:0] speed_out_q;
	reg [5:0] width_out_q;
	reg [2:0] l0s_out_q;

	// registered copies; bad width codes fall back to x1
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			speed_out_q <= `PLCR_SPD_RST;
			width_out_q <= `PLCR_WID_X1;
			l0s_out_q   <= `PLCR_L0S_SEPARATE;
		end else begin
			speed_out_q <= max_speed_field;
			width_out_q <= width_valid(max_width_field) ? max_width_field
				: `PLCR_WID_X1;
			l0s_out_q   <= quick_idle_exit_latency;
		end
	end

	assign MAX_SPEED_O      = speed_out_q;
	assign TRAIN_WIDTH_O    = width_out_q;
	assign QUICK_EXIT_LAT_O = l0s_out_q;
	assign SHARED_REFCLK_O  = shclk_q;
	assign UNLOCKED_O       = unlock_q;

endmodule // plcr_top

// ---- verification/plcr_assertions.sv ----
/* port-level properties of the link capability block.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "plcr_regs.vh"
module plcr_checker (
	input wire                CLK_I,
	input wire                SYS_RST_I,
	input wire [`PLCR_AW-1:0] ADDR_I,
	input wire [31:0]         WDATA_I,
	input wire                WR_I,
	input wire                RD_I,
	input wire [31:0]         RDATA_O,
	input wire                UPSTREAM_I,
	input wire                LEGACY_MODE_I,
	input wire [7:0]          PORT_NUM_I,
	input wire [5:0]          CFG_WIDTH_I,
	input wire [3:0]          MAX_SPEED_O,
	input wire [5:0]          TRAIN_WIDTH_O,
	input wire [2:0]          QUICK_EXIT_LAT_O,
	input wire                SHARED_REFCLK_O,
	input wire                UNLOCKED_O
);
	reg [1:0] lock_cnt_q;
	reg       ovr_q;
	reg       rd_cap_q;
	// locked run length, latency override seen, capability read pending
	always @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			lock_cnt_q <= 2'h0;
			ovr_q <= 1'b0;
			rd_cap_q <= 1'b0;
		end else begin
			lock_cnt_q <= UNLOCKED_O ? 2'h0 : (lock_cnt_q == 2'h3 ? 2'h3 : lock_cnt_q + 2'h1);
			ovr_q <= ovr_q | (WR_I && UNLOCKED_O && ADDR_I == 12'h04c);
			rd_cap_q <= RD_I && ADDR_I == 12'h04c;
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	reset_values_a: assert property ($past(SYS_RST_I) |->
		MAX_SPEED_O == 4'h1 && QUICK_EXIT_LAT_O == 3'h5)
		else $error("values after reset wrong");
	aspm_fixed_a: assert property (rd_cap_q |-> RDATA_O[11:10] == 2'h3)
		else $error("power state support not 3");
	reserved_zero_a: assert property (rd_cap_q |-> RDATA_O[23:22] == 2'h0)
		else $error("reserved bits set");
	port_index_a: assert property (rd_cap_q && $stable(PORT_NUM_I) |->
		RDATA_O[31:24] == PORT_NUM_I)
		else $error("port index wrong");
	train_width_a: assert property (TRAIN_WIDTH_O == 6'h01 ||
		TRAIN_WIDTH_O == 6'h02 || TRAIN_WIDTH_O == 6'h04)
		else $error("train width invalid");
	speed_locked_a: assert property (lock_cnt_q == 2'h3 |-> $stable(MAX_SPEED_O))
		else $error("speed changed while locked");
	quick_latency_a: assert property (!ovr_q &&
		SHARED_REFCLK_O == $past(SHARED_REFCLK_O) && SHARED_REFCLK_O == $past(SHARED_REFCLK_O, 2)
		|-> QUICK_EXIT_LAT_O == (SHARED_REFCLK_O ? 3'h3 : 3'h5))
		else $error("quick exit latency wrong");
	upstream_active_a: assert property (rd_cap_q && UPSTREAM_I |-> !RDATA_O[20])
		else $error("link active set upstream");
	legacy_notify_a: assert property (rd_cap_q && !ovr_q && LEGACY_MODE_I |-> !RDATA_O[21])
		else $error("bandwidth notify set in legacy mode");
	surprise_down_a: assert property (rd_cap_q && !ovr_q |-> RDATA_O[19] == !UPSTREAM_I)
		else $error("surprise down bit wrong");
	deep_latency_a: assert property (rd_cap_q && !ovr_q |-> RDATA_O[18:15] == 4'h2)
		else $error("deep latency or refclk removal wrong");
	cover property (WR_I && ADDR_I == 12'h04c && UNLOCKED_O);
	cover property (rd_cap_q && SHARED_REFCLK_O);
	cover property (rd_cap_q && UPSTREAM_I && LEGACY_MODE_I);
endmodule // plcr_checker
bind plcr_top plcr_checker chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .UPSTREAM_I(UPSTREAM_I),
	.LEGACY_MODE_I(LEGACY_MODE_I), .PORT_NUM_I(PORT_NUM_I), .CFG_WIDTH_I(CFG_WIDTH_I),
	.MAX_SPEED_O(MAX_SPEED_O), .TRAIN_WIDTH_O(TRAIN_WIDTH_O), .QUICK_EXIT_LAT_O(QUICK_EXIT_LAT_O),
	.SHARED_REFCLK_O(SHARED_REFCLK_O), .UNLOCKED_O(UNLOCKED_O));

// ---- verification/test_plcr_top.sv ----
/* self-checking bench: straps, reset values, lock gate, latency and
   width override against a bench model. assumes plcr_top and checker. */
`timescale 1ns/1ps
`include "plcr_regs.vh"
module test_plcr_top;
	reg         CLK_I = 1'b0;
	reg         SYS_RST_I = 1'b1;
	reg  [11:0] ADDR_I = 12'h000;
	reg  [31:0] WDATA_I = 32'h0;
	reg         WR_I = 1'b0;
	reg         RD_I = 1'b0;
	reg         UPSTREAM_I = 1'b0;
	reg         LEGACY_MODE_I = 1'b0;
	reg  [7:0]  PORT_NUM_I = 8'h00;
	reg  [5:0]  CFG_WIDTH_I = 6'h01;
	wire [31:0] RDATA_O;
	wire [3:0]  MAX_SPEED_O;
	wire [5:0]  TRAIN_WIDTH_O;
	wire [2:0]  QUICK_EXIT_LAT_O;
	wire        SHARED_REFCLK_O;
	wire        UNLOCKED_O;
	integer     n_fail = 0;
	integer     comparisons = 0;
	integer     k;
	integer     i;
	reg  [31:0] rnd = 32'h069a;
	reg  [31:0] v;
	reg  [31:0] m_ctl;
	reg  [3:0]  m_spd;
	reg  [5:0]  m_wid;
	reg  [2:0]  m_l0s, m_l1;
	reg         m_ovr, m_cpm, m_sde, m_dla, m_bwn;
	plcr_top uut (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .UPSTREAM_I(UPSTREAM_I),
		.LEGACY_MODE_I(LEGACY_MODE_I), .PORT_NUM_I(PORT_NUM_I), .CFG_WIDTH_I(CFG_WIDTH_I),
		.MAX_SPEED_O(MAX_SPEED_O), .TRAIN_WIDTH_O(TRAIN_WIDTH_O),
		.QUICK_EXIT_LAT_O(QUICK_EXIT_LAT_O), .SHARED_REFCLK_O(SHARED_REFCLK_O),
		.UNLOCKED_O(UNLOCKED_O));
	// 125 MHz clock
	always #4 CLK_I = ~CLK_I;
	// -----------------------------------------------------------
	// model and bus tasks
	// -----------------------------------------------------------
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [31:0] exp_cap();
		exp_cap = {PORT_NUM_I, 2'h0, m_bwn, m_dla, m_sde, m_cpm, m_l1,
			m_ovr ? m_l0s : (m_ctl[6] ? 3'h3 : 3'h5), 2'h3, m_wid, m_spd};
	endfunction
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("[FAIL] %0s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		@(posedge CLK_I);
		WR_I <= 1'b1;
		ADDR_I <= a;
		WDATA_I <= d;
		@(posedge CLK_I);
		WR_I <= 1'b0;
		if (a == 12'h04c && m_ctl[0]) begin
			{m_bwn, m_dla, m_sde, m_cpm, m_l1, m_l0s, v[1:0], m_wid, m_spd} = d[21:0];
			m_dla = m_dla & ~UPSTREAM_I;
			m_ovr = 1'b1;
		end
		if (a == 12'h0f0)
			m_ctl = d & 32'h41;
	endtask
	task rd(input [11:0] a, input [31:0] e, input string nm);
		@(posedge CLK_I);
		RD_I <= 1'b1;
		ADDR_I <= a;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1;
		check(nm, RDATA_O, e);
	endtask
	task do_reset;
		SYS_RST_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		SYS_RST_I <= 1'b0;
		repeat (3) @(posedge CLK_I);
		{m_spd, m_wid, m_ovr, m_l1, m_cpm, m_ctl} = {4'h1, CFG_WIDTH_I, 1'b0, 3'h2, 1'b0, 32'h0};
		{m_sde, m_dla, m_bwn} = {~UPSTREAM_I, ~UPSTREAM_I, ~UPSTREAM_I & ~LEGACY_MODE_I};
	endtask
	task give_verdict;
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// -----------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------
	initial begin
		for (k = 0; k < 4; k = k + 1) begin
			if (k != 0)
				@(posedge CLK_I);
			UPSTREAM_I <= k[0] ^ k[1];
			LEGACY_MODE_I <= k[1] & ~k[0];
			PORT_NUM_I <= rnd[7:0];
			CFG_WIDTH_I <= (k == 0) ? 6'h01 : (k == 1) ? 6'h02 : 6'h04;
			rnd = lfsr(rnd);
			do_reset;
			rd(12'h04c, exp_cap(), "cap_rst");
			check("width", {26'h0, TRAIN_WIDTH_O}, {26'h0, CFG_WIDTH_I});
		end
		wr(12'h04c, rnd);
		rnd = lfsr(rnd);
		rd(12'h04c, exp_cap(), "locked");
		wr(12'h0f0, 32'h40);
		rd(12'h04c, exp_cap(), "shared");
		check("qlat", {29'h0, QUICK_EXIT_LAT_O}, 32'h3);
		wr(12'h0f0, 32'h0);
		rd(12'h04c, exp_cap(), "separate");
		wr(12'h0f0, 32'hffff_ffff);
		rd(12'h0f0, 32'h41, "ctl");
		check("unl_o", {31'h0, UNLOCKED_O}, {31'h0, m_ctl[0]});
		check("shclk_o", {31'h0, SHARED_REFCLK_O}, {31'h0, m_ctl[6]});
		// unlocked overrides, invalid width codes first
		for (i = 0; i < 6; i = i + 1) begin
			v = rnd;
			if (i < 4)
				v[9:4] = (i == 3) ? 6'h04 : 6'(i * 3);
			wr(12'h04c, v);
			rnd = lfsr(rnd);
			rd(12'h04c, exp_cap(), "unlocked");
			check("train", {26'h0, TRAIN_WIDTH_O},
				(m_wid == 6'h01 || m_wid == 6'h02 || m_wid == 6'h04) ? {26'h0, m_wid} : 32'h1);
			check("spd_o", {28'h0, MAX_SPEED_O}, {28'h0, m_spd});
		end
		wr(12'h050, rnd);
		rd(12'h050, 32'h0, "unmapped");
		rd(12'h04c, exp_cap(), "after_unm");
		wr(12'h0f0, 32'h0);
		wr(12'h04c, ~rnd);
		rd(12'h04c, exp_cap(), "relocked");
		check("lock_o", {31'h0, UNLOCKED_O}, 32'h0);
		give_verdict;
	end
	// watchdog
	initial begin
		#20000;
		n_fail = n_fail + 1;
		give_verdict;
	end
endmodule // test_plcr_top
